// ### adc_sweep_sequencer_tb.sv
// Purpose: Self-checking bench of the sweep sequencer.
// Assumes: Avalon-MM slave with waitrequest; converter model on far side.
// Notes: Covers registers, manual runs, full flag, rates and sweep.
`timescale 1ns/1ps
module adc_sweep_sequencer_tb;
  logic sys_clk, reset, read, write, conv_done, slow, waitrequest, irq;
  logic amp_single_end_force;
  logic [7:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [11:0] conv_data, last_data;
  logic [2:0] ch;
  adcss_pkg::adcss_conv_t conv;
  adcss_pkg::adcss_mem_t mem;
  int n_fail, samples_checked, cyc, t0, n0;

  adcss_seq u_dut (.sys_clk(sys_clk), .reset(reset), .address(address),
    .read(read), .write(write), .byteenable(4'hF), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .conv_done(conv_done), .conv_data(conv_data), .conv(conv), .mem(mem),
    .amp_single_end_force(amp_single_end_force));
  adcss_conv_model u_conv (.sys_clk(sys_clk), .reset(reset), .slow(slow),
    .conv(conv), .conv_done(conv_done), .conv_data(conv_data),
    .last_data(last_data));

  // Clock at 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Cycle count for spacing checks
  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One bus request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic wait_start();
    do @(posedge sys_clk); while (conv.start !== 1'b1);
  endtask : wait_start

  // Next stored result: address and the converter's value
  task automatic wait_wr(input logic [9:0] a);
    do @(posedge sys_clk); while (mem.we !== 1'b1);
    chk("mem addr", 32'(a), 32'(mem.addr));
    chk("mem data", {20'h0, last_data}, 32'(mem.data));
  endtask : wait_wr

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Watchdog against a stalled handshake
  initial begin
    repeat (80000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end

  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    slow = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    bus(0, adcss_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", adcss_pkg::CTRL_RST, rd);
    chk("amp reset", 32'h0, 32'(amp_single_end_force));
    bus(1, adcss_pkg::OFS_CFG0, 32'h0031_0050);
    bus(0, adcss_pkg::OFS_CFG0, 32'h0);
    chk("cfg pair", 32'h0031_0050, rd);
    for (int i = 1; i < 4; i++) bus(1, 8'(8'h6C + 4 * i), 32'h0);
    bus(0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rd);
    bus(1, adcss_pkg::OFS_CTRL, 32'h0000_0201);
    repeat (2) @(posedge sys_clk);
    chk("amp force", 32'h1, 32'(amp_single_end_force));
    bus(1, adcss_pkg::OFS_MASK, 32'h0000_00FF);
    $display("Test registers done");
    // manual run on channel 3 ignores the sweep configurations
    bus(1, adcss_pkg::OFS_CTRL, 32'h0000_00CB);
    for (int i = 0; i < 64; i++) wait_wr(10'(384 + 2 * i));
    chk("manual pair", 32'h0E, 32'({conv.chan, conv.diff, conv.neg}));
    repeat (3) @(posedge sys_clk);
    chk("irq full", 32'h1, 32'(irq));
    bus(1, adcss_pkg::OFS_MASK, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk("irq masked", 32'h0, 32'(irq));
    bus(1, adcss_pkg::OFS_MASK, 32'h0000_00FF);
    bus(0, adcss_pkg::OFS_STAT, 32'h0);
    chk("stat full", 32'h08, rd);
    repeat (3) @(posedge sys_clk);
    chk("irq clear", 32'h0, 32'(irq));
    wait_wr(10'(384));
    $display("Test manual fill done");
    bus(1, adcss_pkg::OFS_CTRL, 32'h0000_00BB);
    wait_start();
    wait_start();
    chk("single neg", 32'h09, 32'({conv.chan, conv.diff, conv.neg}));
    // start spacing of 16, 8 and 4 ticks on the positive member
    for (int c = 0; c < 3; c++) begin
      bus(1, adcss_pkg::OFS_CTRL, 32'h0000_00D3 | 32'(c << 2));
      wait_start();
      t0 = cyc;
      wait_start();
      chk("single pos", 32'h0C, 32'({conv.chan, conv.diff, conv.neg}));
      chk("rate gap", 32'h1, 32'((cyc - t0) >= (500 >> c) - 4 &&
          (cyc - t0) <= (500 >> c) + 4));
    end
    $display("Test manual modes done");
    // one-shot channel 0 once, continuous channel 1 repeated
    // Stop manual first so its last result cannot land in the sweep
    bus(1, adcss_pkg::OFS_CTRL, 32'h0);
    repeat (100) @(posedge sys_clk);
    slow <= 1'b1;
    bus(1, adcss_pkg::OFS_CTRL, 32'h0000_0002);
    n0 = 0;
    for (int i = 0; i < 5; i++) begin
      wait_start();
      ch = conv.chan;
      n0 += int'(ch == 3'd0);
      chk("sweep chan", 32'h1, 32'(ch <= 3'd1));
      chk("sweep cfg", (ch == 3'd0) ? 32'h0 : 32'h11,
          32'({conv.diff, conv.samp}));
      wait_wr(10'(ch * 128 + ((ch == 3'd0) ? 0 : 2 * (i - n0))));
    end
    chk("one shot", 32'h1, 32'(n0));
    $display("Test sweep done");
    complete_run();
  end
endmodule : adc_sweep_sequencer_tb

// ### adcss_conv_model.sv
// Purpose: Behavioural converter answering the sequencer's start pulses.
// Assumes: Start is a one-cycle pulse; one conversion at a time.
// Notes: Data toggles while not held, so a stale value never looks valid.
`timescale 1ns/1ps
module adcss_conv_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic slow,
  input wire adcss_pkg::adcss_conv_t conv,
  output logic conv_done,
  output logic [11:0] conv_data,
  output logic [11:0] last_data
);
  int cnt_r;
  int dly;
  logic [7:0] seq_r;
  // Slow answers stretch the conversion time
  assign dly = slow ? 40 : 6;
  // Result stable from before done rises until done falls
  always @(posedge sys_clk) begin
    if (reset) begin
      cnt_r <= 0;
      conv_done <= 1'b0;
      conv_data <= 12'hA5A;
      seq_r <= 8'h00;
      last_data <= 12'h000;
    end else if (conv.start) begin
      cnt_r <= 1;
    end else if (cnt_r != 0) begin
      cnt_r <= (cnt_r == dly + 9) ? 0 : cnt_r + 1;
      if (cnt_r == dly) begin
        conv_data <= {1'b0, conv.chan, seq_r};
        last_data <= {1'b0, conv.chan, seq_r};
        seq_r <= seq_r + 8'h01;
      end
      conv_done <= (cnt_r >= dly + 1) && (cnt_r < dly + 9);
    end else begin
      conv_data <= ~conv_data;
    end
  end
endmodule : adcss_conv_model

// ### adcss_pkg.sv
// Purpose: Shared constants and types of the converter sweep sequencer.
// Assumes: 40 MHz system clock, Avalon-MM register access.
// Notes: Offsets are byte addresses on a 32-bit data bus.
package adcss_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_INFO = 8'h0C;
  localparam logic [7:0] OFS_CFG0 = 8'h6C;
  localparam logic [7:0] OFS_CFG1 = 8'h70;
  localparam logic [7:0] OFS_CFG2 = 8'h74;
  localparam logic [7:0] OFS_CFG3 = 8'h78;
  // Control register fields
  localparam int CTL_MANUAL = 0;
  localparam int CTL_EN = 1;
  localparam int CTL_RATE_LSB = 2;
  localparam int CTL_SINGLE = 4;
  localparam int CTL_NEG = 5;
  localparam int CTL_CH_LSB = 6;
  localparam int CTL_AMP_SE = 9;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // Channel configuration fields, one 16-bit half per channel
  localparam int CF_SAMP_LSB = 0;
  localparam int CF_EN = 4;
  localparam int CF_DIFF = 5;
  localparam int CF_ONESHOT = 6;
  // Rate selection codes
  localparam logic [1:0] RATE_80K = 2'h0;
  localparam logic [1:0] RATE_160K = 2'h1;
  // Timing: unit tick T comes from a 1.28 MHz rate
  localparam int SYS_CLK_KHZ = 40000;
  localparam int T_CLK_KHZ = 1280;
  localparam int RATE80_T = T_CLK_KHZ / 80;
  localparam int RATE160_T = T_CLK_KHZ / 160;
  localparam int RATE320_T = T_CLK_KHZ / 320;
  localparam int SAMP_BASE_T = 2;
  localparam int SAMP_STEP_T = 4;
  // Memory layout
  localparam int NCH = 8;
  localparam int REGION_BYTES = 128;
  localparam int SAMPLE_BYTES = 2;
  localparam int SAMPLES_PER_REGION = REGION_BYTES / SAMPLE_BYTES;
  // Converter request
  typedef struct packed {
    logic start;
    logic [2:0] chan;
    logic diff;
    logic neg;
    logic [3:0] samp;
  } adcss_conv_t;
  // Sample memory write
  typedef struct packed {
    logic we;
    logic [9:0] addr;
    logic [15:0] data;
  } adcss_mem_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_CONV = 3'h4
  } adcss_fsm_t;
endpackage : adcss_pkg

// ### adcss_seq.sv
// Purpose: Manual and sweep conversion sequencer with result storage.
// Assumes: Converter raises conv_done level with stable conv_data.
// Notes: Function
// Function
// - Sixteen inputs grouped into eight channel configurations.
// - Manual mode after reset; rate 80k, 160k or 320k.
// - Manual pair differential by default, else single on pos or neg.
// - Enabled manual mode converts repeatedly into the channel region.
// - 128-byte region per channel; full region sets its flag.
// - Each 12-bit result takes two bytes, 64 per region.
// - Manual bit cleared selects automatic sweep of enabled channels.
// - Sweep results go to the same channel regions.
// - Bit 4 enable, bit 5 differential, bit 6 one-shot.
// - Channel configurations act only in sweep mode.
// - Each control word holds two channel configurations.
// - Amp single-end bit forces amplifier to single-ended.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module adcss_seq (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  output adcss_pkg::adcss_conv_t conv,
  output adcss_pkg::adcss_mem_t mem,
  output logic amp_single_end_force
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [3:0][31:0] cfg;
    logic [7:0][5:0] ptr;
    logic [7:0] shot;
    adcss_pkg::adcss_fsm_t fsm;
    logic one;
    logic man;
    logic [5:0] cnt;
    logic [5:0] tgt;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic [11:0] data_s1;
    logic [11:0] data_s2;
    logic wreq;
    logic [31:0] rdata;
    logic irq;
    logic amp_se;
    adcss_pkg::adcss_conv_t conv;
    adcss_pkg::adcss_mem_t mem;
  } adcss_state_t;

  adcss_state_t s;
  adcss_state_t n;
  logic tick;
  logic acc;
  logic done_edge;
  logic [7:0] elig;
  logic [7:0][15:0] hcfg;
  logic [3:0] pick;
  logic [15:0] ccfg;
  logic [2:0] mch;
  logic [1:0] rate;

  // T tick at 1.28 MHz from the 40 MHz clock
  adcss_tick #(
    .INC(adcss_pkg::T_CLK_KHZ),
    .MOD(adcss_pkg::SYS_CLK_KHZ),
    .W(16)
  ) u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick_r(tick)
  );

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] half(input logic [3:0][31:0] cfg,
                                       input logic [2:0] ch);
    return ch[0] ? cfg[ch[2:1]][31:16] : cfg[ch[2:1]][15:0];
  endfunction : half

  // Next eligible channel after cur, round robin; bit 3 means found
  function automatic logic [3:0] next_ch(input logic [2:0] cur,
                                         input logic [7:0] el);
    logic [3:0] r;
    logic [2:0] c;
    r = 4'h0;
    for (int k = 8; k >= 1; k--) begin
      c = cur + 3'(k);
      if (el[c]) begin
        r = {1'h1, c};
      end
    end
    return r;
  endfunction : next_ch

  // Eligibility of each channel in sweep mode
  // eight channel slots
  always_comb begin
    for (int i = 0; i < adcss_pkg::NCH; i++) begin
      hcfg[i] = half(s.cfg, 3'(i));
      elig[i] = hcfg[i][adcss_pkg::CF_EN] &
                ~(hcfg[i][adcss_pkg::CF_ONESHOT] & s.shot[i]);
    end
  end

  assign acc = (read | write) & ~s.wreq;
  assign done_edge = s.done_s2 & ~s.done_s3;
  assign pick = next_ch(s.conv.chan, elig);
  assign ccfg = half(s.cfg, pick[2:0]);
  assign mch = s.ctrl[adcss_pkg::CTL_CH_LSB +: 3];
  assign rate = s.ctrl[adcss_pkg::CTL_RATE_LSB +: 2];

  // Whole next state; bus, flags and sequencer
  always_comb begin
    n = s;
    n.conv.start = 1'h0;
    n.mem.we = 1'h0;
    // Converter handshake crosses in from the analog side
    n.done_s1 = conv_done;
    n.done_s2 = s.done_s1;
    n.done_s3 = s.done_s2;
    n.data_s1 = conv_data;
    n.data_s2 = s.data_s1;
    // One wait state; the request completes on the following edge
    n.wreq = ~((read | write) & s.wreq);
    if (read & s.wreq) begin
      unique case (address)
        adcss_pkg::OFS_CTRL: n.rdata = s.ctrl;
        adcss_pkg::OFS_STAT: n.rdata = {24'h0, s.stat};
        adcss_pkg::OFS_MASK: n.rdata = {24'h0, s.mask};
        adcss_pkg::OFS_INFO: n.rdata = {28'h0,
            s.fsm != adcss_pkg::ST_IDLE, s.conv.chan};
        adcss_pkg::OFS_CFG0: n.rdata = s.cfg[0];
        adcss_pkg::OFS_CFG1: n.rdata = s.cfg[1];
        adcss_pkg::OFS_CFG2: n.rdata = s.cfg[2];
        adcss_pkg::OFS_CFG3: n.rdata = s.cfg[3];
        default: n.rdata = 32'h0;
      endcase
    end
    if (acc & write) begin
      unique case (address)
        adcss_pkg::OFS_CTRL: n.ctrl = merge(s.ctrl, writedata, byteenable);
        adcss_pkg::OFS_MASK: n.mask = 8'(merge({24'h0, s.mask},
                                                writedata, byteenable));
        adcss_pkg::OFS_CFG0: n.cfg[0] = merge(s.cfg[0], writedata, byteenable);
        adcss_pkg::OFS_CFG1: n.cfg[1] = merge(s.cfg[1], writedata, byteenable);
        adcss_pkg::OFS_CFG2: n.cfg[2] = merge(s.cfg[2], writedata, byteenable);
        adcss_pkg::OFS_CFG3: n.cfg[3] = merge(s.cfg[3], writedata, byteenable);
        default: n.ctrl = s.ctrl;
      endcase
    end
    // read clears only the flags it reported; a newer one survives
    if (acc & read & (address == adcss_pkg::OFS_STAT)) begin
      n.stat = s.stat & ~s.rdata[7:0];
    end
    // One-shot history lasts one sweep session only
    if (s.ctrl[adcss_pkg::CTL_MANUAL] | ~s.ctrl[adcss_pkg::CTL_EN]) begin
      n.shot = 8'h0;
    end
    // period count; ticks are counted in every state
    n.cnt = s.cnt + {5'h0, tick};
    unique case (s.fsm)
      adcss_pkg::ST_IDLE: begin
        // Manual keeps its count so the period runs start to start
        if (~s.ctrl[adcss_pkg::CTL_EN] | ~s.ctrl[adcss_pkg::CTL_MANUAL]) begin
          n.cnt = 6'h0;
        end
        n.man = s.ctrl[adcss_pkg::CTL_MANUAL];
        if (s.ctrl[adcss_pkg::CTL_EN]) begin
          if (s.ctrl[adcss_pkg::CTL_MANUAL]) begin
            n.conv.chan = mch;
            n.conv.diff = ~s.ctrl[adcss_pkg::CTL_SINGLE];
            n.conv.neg = s.ctrl[adcss_pkg::CTL_SINGLE] &
                         s.ctrl[adcss_pkg::CTL_NEG];
            n.conv.samp = 4'h0;
            n.one = 1'h0;
            n.tgt = (rate == adcss_pkg::RATE_80K) ? 6'(adcss_pkg::RATE80_T) :
                    (rate == adcss_pkg::RATE_160K) ?
                    6'(adcss_pkg::RATE160_T) : 6'(adcss_pkg::RATE320_T);
            n.fsm = adcss_pkg::ST_WAIT;
          end else if (pick[3]) begin
            n.conv.chan = pick[2:0];
            n.conv.diff = ccfg[adcss_pkg::CF_DIFF];
            n.conv.neg = 1'h0;
            n.conv.samp = ccfg[adcss_pkg::CF_SAMP_LSB +: 4];
            n.one = ccfg[adcss_pkg::CF_ONESHOT];
            n.tgt = 6'(adcss_pkg::SAMP_BASE_T) +
                    6'(adcss_pkg::SAMP_STEP_T) *
                    {2'h0, ccfg[adcss_pkg::CF_SAMP_LSB +: 4]};
            n.fsm = adcss_pkg::ST_WAIT;
          end
        end
      end
      adcss_pkg::ST_WAIT: begin
        if (~s.ctrl[adcss_pkg::CTL_EN] |
            (s.ctrl[adcss_pkg::CTL_MANUAL] != s.man)) begin
          n.fsm = adcss_pkg::ST_IDLE;
        end else if (tick) begin
          if (n.cnt >= s.tgt) begin
            n.conv.start = 1'h1;
            n.cnt = 6'h0;
            n.fsm = adcss_pkg::ST_CONV;
          end
        end
      end
      adcss_pkg::ST_CONV: begin
        if (done_edge) begin
          n.fsm = adcss_pkg::ST_IDLE;
          if (s.one) begin
            n.shot[s.conv.chan] = 1'h1;
          end
          if (~s.stat[s.conv.chan]) begin
            n.mem.we = 1'h1;
            n.mem.addr = {s.conv.chan, s.ptr[s.conv.chan], 1'h0};
            n.mem.data = {4'h0, s.data_s2};
            n.ptr[s.conv.chan] = s.ptr[s.conv.chan] + 6'h1;
            if (s.ptr[s.conv.chan] ==
                6'(adcss_pkg::SAMPLES_PER_REGION - 1)) begin
              n.stat[s.conv.chan] = 1'h1;
            end
          end
        end
      end
      default: n.fsm = adcss_pkg::ST_IDLE;
    endcase
    // Flag wins over the read clear; mask gates the level output
    n.irq = |(n.stat & n.mask);
    n.amp_se = n.ctrl[adcss_pkg::CTL_AMP_SE];
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
      s.ctrl <= adcss_pkg::CTRL_RST;
      s.wreq <= 1'h1;
      s.fsm <= adcss_pkg::ST_IDLE;
    end else begin
      s <= n;
    end
  end

  assign readdata = s.rdata;
  assign waitrequest = s.wreq;
  assign irq = s.irq;
  assign conv = s.conv;
  assign mem = s.mem;
  assign amp_single_end_force = s.amp_se;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Checks of sequencer behaviour
  manual_after_reset_a: assert property (
    $fell(reset) |-> s.ctrl[adcss_pkg::CTL_MANUAL])
    else $error("not manual after reset");
  manual_pair_a: assert property (
    s.fsm == adcss_pkg::ST_IDLE && s.ctrl[adcss_pkg::CTL_EN] &&
    s.ctrl[adcss_pkg::CTL_MANUAL] |=> conv.chan == $past(mch) &&
    conv.diff != $past(s.ctrl[adcss_pkg::CTL_SINGLE]))
    else $error("manual pair wrong");
  sweep_enabled_a: assert property (
    conv.start & ~s.ctrl[adcss_pkg::CTL_MANUAL] |->
    hcfg[conv.chan][adcss_pkg::CF_EN])
    else $error("disabled channel converted");
  oneshot_skip_a: assert property (
    conv.start & ~s.ctrl[adcss_pkg::CTL_MANUAL] |-> ~s.shot[conv.chan])
    else $error("one-shot channel repeated");
  start_pulse_a: assert property (
    conv.start |=> ~conv.start [*2])
    else $error("start not a pulse");
  mem_region_a: assert property (
    mem.we |-> mem.addr[9:7] == conv.chan && ~mem.addr[0])
    else $error("write outside region");
  full_flag_a: assert property (
    mem.we && mem.addr[6:1] == 6'h3F |-> s.stat[conv.chan])
    else $error("full flag missing");
  mem_after_done_a: assert property (
    mem.we |-> $past(s.fsm) == adcss_pkg::ST_CONV && $past(done_edge))
    else $error("write without result");
  sample_wait_a: assert property (
    s.fsm == adcss_pkg::ST_WAIT && tick && s.cnt + 6'h1 >= s.tgt &&
    s.ctrl[adcss_pkg::CTL_EN] && s.ctrl[adcss_pkg::CTL_MANUAL] == s.man
    |=> conv.start)
    else $error("start late");
  amp_force_a: assert property (
    $rose(s.ctrl[adcss_pkg::CTL_AMP_SE]) |-> amp_single_end_force)
    else $error("amp force lag");
  one_wait_a: assert property (
    ~waitrequest |=> waitrequest)
    else $error("wait state wrong");
  cover_manual_c: cover property (conv.start & s.ctrl[0]);
  cover_sweep_c: cover property (conv.start & ~s.ctrl[0]);
  cover_full_c: cover property ($rose(irq));
endmodule : adcss_seq

// ### adcss_tick.sv
// Purpose: Fractional divider giving a one-cycle enable at a slow rate.
// Assumes: INC below MOD; average rate is sys rate times INC over MOD.
// Notes: Jitter is one system cycle, harmless against sample times.
`timescale 1ns/1ps
module adcss_tick #(
  parameter int INC = 1280,
  parameter int MOD = 40000,
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  output logic tick_r
);
  typedef struct packed {
    logic [W-1:0] acc;
    logic tick;
  } adcss_tick_t;
  adcss_tick_t s;
  adcss_tick_t n;
  logic [W:0] sum;

  // Phase accumulator, wraps once per output tick
  always_comb begin
    n = s;
    sum = {1'h0, s.acc} + (W+1)'(INC);
    n.tick = (sum >= (W+1)'(MOD));
    n.acc = n.tick ? W'(sum - (W+1)'(MOD)) : sum[W-1:0];
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick_r = s.tick;
endmodule : adcss_tick
